// ===== hdl/sfc_byte_reg.v
// one byte-wide read/write configuration register with a synchronous reset value
module sfc_byte_reg #(
  parameter [7:0] RESET_VAL = 8'h00,
  parameter [7:0] WMASK = 8'hff
) (
  // clock and reset
  input wire clk_i,
  input wire rstn_i,
  // write port
  input wire wr_en_i,
  input wire [7:0] wr_data_i,
  // stored value
  output wire [7:0] value_o
);

  reg [7:0] val_q;
  wire [7:0] val_d;

  // bits outside the mask keep their reset value forever
  assign val_d = (val_q & ~WMASK) | (wr_data_i & WMASK);

  always @(posedge clk_i) begin
    if (!rstn_i) begin
      val_q <= RESET_VAL;
    end else if (wr_en_i) begin
      val_q <= val_d;
    end
  end

  assign value_o = val_q;

endmodule // sfc_byte_reg

// ===== hdl/sfc_cal_start.v
// turns a qualified write of the integer low byte into a one-cycle calibration start
module sfc_cal_start (
  // clock and reset
  input wire clk_i,
  input wire rstn_i,
  // trigger conditions
  input wire int_low_wr_i,
  input wire cal_enable_i,
  // start strobe
  output wire cal_start_o
);

  reg start_q;
  wire start_d;

  // the enable is sampled as stored before the write lands, so a write to
  // the calibration control in the same cycle cannot race it
  assign start_d = int_low_wr_i & cal_enable_i;

  always @(posedge clk_i) begin
    if (!rstn_i) begin
      start_q <= 1'b0;
    end else begin
      start_q <= start_d;
    end
  end

  assign cal_start_o = start_q;

endmodule // sfc_cal_start

// ===== hdl/sfc_config_regs.v
// byte-wide configuration register bank of the frequency synthesizer
//
// Operation
// - two read-only maker code bytes, high byte at 0x0d, writes ignored
// - twelve-bit integer word, low byte 0x10 resets 0x80, high nibble 0x11[3:0]
// - writing integer low byte starts calibration only when calibration_enable is set
// - calibration_enable is bit 7 of 0x20, resets to zero
// - output divider field 0x11[7:6] selects divide by 1, 2, 4 or 8
// - bit 5 of 0x11 picks integer mode when set, fractional when clear
// - bit 4 of 0x11 inverts both rf outputs when set
// - 25-bit first fraction word from 0x12..0x14 plus 0x15 bit 0
// - 24-bit second fraction word from 0x17..0x19, low byte first
// - 0x15[7:6] picks vco core only while core override flag set
// - 0x15[5:2] sets bias level 0..15 only while bias override flag set
// - 0x16 picks band within core while band override flag set
// - 0x0f bits 7..1 read zero, bit 0 is a spare read/write bit
// - 0x1a holds low byte of second modulus word, resets zero
`include "sfc_regs.vh"

module sfc_config_regs #(
  // arbitrary neutral maker code, not a real identifier
  parameter [15:0] MAKER_CODE = 16'h1234
) (
  // clock and reset
  input wire clk_i,
  input wire rstn_i,
  // register access from the serial interface
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [`SFC_ADDR_W-1:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  output wire [7:0] reg_rdata_o,
  // override flags held in other registers
  input wire core_override_flag_i,
  input wire bias_override_flag_i,
  input wire band_override_flag_i,
  // synthesizer settings
  output wire [11:0] int_word_o,
  output wire [24:0] first_fraction_word_o,
  output wire [23:0] second_fraction_word_o,
  output wire [7:0] second_modulus_low_o,
  output wire [3:0] output_divide_ratio_o,
  output wire integer_mode_o,
  output wire output_polarity_invert_o,
  output wire spare_rw_bit_o,
  output wire calibration_enable_o,
  // manual vco settings, valid only while the matching flag is set
  output wire manual_core_valid_o,
  output wire [1:0] manual_core_select_o,
  output wire manual_bias_valid_o,
  output wire [3:0] manual_bias_level_o,
  output wire manual_band_valid_o,
  output wire [7:0] manual_band_select_o,
  // calibration start strobe
  output wire cal_start_o
);

  // ==========================================================
  // write decode
  // ==========================================================
  localparam N_RW = 13;
  localparam I_SPARE = 0;
  localparam I_INT_LOW = 1;
  localparam I_OUTDIV = 2;
  localparam I_F1B0 = 3;
  localparam I_F1B1 = 4;
  localparam I_F1B2 = 5;
  localparam I_CORE = 6;
  localparam I_BAND = 7;
  localparam I_F2B0 = 8;
  localparam I_F2B1 = 9;
  localparam I_F2B2 = 10;
  localparam I_MOD2 = 11;
  localparam I_CAL = 12;

  wire [N_RW-1:0] wr_sel;
  wire [8*N_RW-1:0] reg_val;

  // maker code bytes have no write select, so writes there fall away
  assign wr_sel[I_SPARE] = reg_wr_i && (reg_addr_i == `SFC_OFF_SPARE);
  assign wr_sel[I_INT_LOW] = reg_wr_i && (reg_addr_i == `SFC_OFF_INT_LOW);
  assign wr_sel[I_OUTDIV] = reg_wr_i && (reg_addr_i == `SFC_OFF_OUTDIV_MODE);
  assign wr_sel[I_F1B0] = reg_wr_i && (reg_addr_i == `SFC_OFF_FRAC1_B0);
  assign wr_sel[I_F1B1] = reg_wr_i && (reg_addr_i == `SFC_OFF_FRAC1_B1);
  assign wr_sel[I_F1B2] = reg_wr_i && (reg_addr_i == `SFC_OFF_FRAC1_B2);
  assign wr_sel[I_CORE] = reg_wr_i && (reg_addr_i == `SFC_OFF_CORE_BIAS);
  assign wr_sel[I_BAND] = reg_wr_i && (reg_addr_i == `SFC_OFF_BAND);
  assign wr_sel[I_F2B0] = reg_wr_i && (reg_addr_i == `SFC_OFF_FRAC2_B0);
  assign wr_sel[I_F2B1] = reg_wr_i && (reg_addr_i == `SFC_OFF_FRAC2_B1);
  assign wr_sel[I_F2B2] = reg_wr_i && (reg_addr_i == `SFC_OFF_FRAC2_B2);
  assign wr_sel[I_MOD2] = reg_wr_i && (reg_addr_i == `SFC_OFF_MOD2_B0);
  assign wr_sel[I_CAL] = reg_wr_i && (reg_addr_i == `SFC_OFF_CAL_CTRL);

  // ==========================================================
  // storage
  // ==========================================================
  // only bit 0 of the spare register stores; the rest reads zero
  sfc_byte_reg #(.RESET_VAL(`SFC_RST_ZERO), .WMASK(8'h01)) u_spare (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .wr_en_i(wr_sel[I_SPARE]),
    .wr_data_i(reg_wdata_i),
    .value_o(reg_val[8*I_SPARE +: 8])
  );

  // integer low byte comes out of reset at 0x80
  sfc_byte_reg #(.RESET_VAL(`SFC_RST_INT_LOW), .WMASK(8'hff)) u_int_low (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .wr_en_i(wr_sel[I_INT_LOW]),
    .wr_data_i(reg_wdata_i),
    .value_o(reg_val[8*I_INT_LOW +: 8])
  );

  // divider, mode, polarity and integer high nibble, all reset zero
  sfc_byte_reg #(.RESET_VAL(`SFC_RST_ZERO), .WMASK(8'hff)) u_outdiv (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .wr_en_i(wr_sel[I_OUTDIV]),
    .wr_data_i(reg_wdata_i),
    .value_o(reg_val[8*I_OUTDIV +: 8])
  );

  // remaining full bytes, all reset to zero; one named instance per byte
  // keeps every register easy to find in the hierarchy
  sfc_byte_reg #(.RESET_VAL(`SFC_RST_ZERO), .WMASK(8'hff)) u_frac1_b0 (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .wr_en_i(wr_sel[I_F1B0]),
    .wr_data_i(reg_wdata_i),
    .value_o(reg_val[8*I_F1B0 +: 8])
  );

  sfc_byte_reg #(.RESET_VAL(`SFC_RST_ZERO), .WMASK(8'hff)) u_frac1_b1 (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .wr_en_i(wr_sel[I_F1B1]),
    .wr_data_i(reg_wdata_i),
    .value_o(reg_val[8*I_F1B1 +: 8])
  );

  sfc_byte_reg #(.RESET_VAL(`SFC_RST_ZERO), .WMASK(8'hff)) u_frac1_b2 (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .wr_en_i(wr_sel[I_F1B2]),
    .wr_data_i(reg_wdata_i),
    .value_o(reg_val[8*I_F1B2 +: 8])
  );

  sfc_byte_reg #(.RESET_VAL(`SFC_RST_ZERO), .WMASK(8'hff)) u_core_bias (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .wr_en_i(wr_sel[I_CORE]),
    .wr_data_i(reg_wdata_i),
    .value_o(reg_val[8*I_CORE +: 8])
  );

  sfc_byte_reg #(.RESET_VAL(`SFC_RST_ZERO), .WMASK(8'hff)) u_band (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .wr_en_i(wr_sel[I_BAND]),
    .wr_data_i(reg_wdata_i),
    .value_o(reg_val[8*I_BAND +: 8])
  );

  sfc_byte_reg #(.RESET_VAL(`SFC_RST_ZERO), .WMASK(8'hff)) u_frac2_b0 (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .wr_en_i(wr_sel[I_F2B0]),
    .wr_data_i(reg_wdata_i),
    .value_o(reg_val[8*I_F2B0 +: 8])
  );

  sfc_byte_reg #(.RESET_VAL(`SFC_RST_ZERO), .WMASK(8'hff)) u_frac2_b1 (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .wr_en_i(wr_sel[I_F2B1]),
    .wr_data_i(reg_wdata_i),
    .value_o(reg_val[8*I_F2B1 +: 8])
  );

  sfc_byte_reg #(.RESET_VAL(`SFC_RST_ZERO), .WMASK(8'hff)) u_frac2_b2 (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .wr_en_i(wr_sel[I_F2B2]),
    .wr_data_i(reg_wdata_i),
    .value_o(reg_val[8*I_F2B2 +: 8])
  );

  sfc_byte_reg #(.RESET_VAL(`SFC_RST_ZERO), .WMASK(8'hff)) u_mod2 (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .wr_en_i(wr_sel[I_MOD2]),
    .wr_data_i(reg_wdata_i),
    .value_o(reg_val[8*I_MOD2 +: 8])
  );

  // only the calibration enable bit is held here; other bits of that
  // register belong to logic outside this bank and read back their reset
  sfc_byte_reg #(.RESET_VAL(`SFC_RST_CAL_CTRL), .WMASK(8'h80)) u_cal (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .wr_en_i(wr_sel[I_CAL]),
    .wr_data_i(reg_wdata_i),
    .value_o(reg_val[8*I_CAL +: 8])
  );

  // ==========================================================
  // field extraction
  // ==========================================================
  wire [7:0] int_low_v;
  wire [7:0] outdiv_v;
  wire [7:0] core_v;
  wire [7:0] cal_v;
  reg [3:0] div_ratio;

  assign int_low_v = reg_val[8*I_INT_LOW +: 8];
  assign outdiv_v = reg_val[8*I_OUTDIV +: 8];
  assign core_v = reg_val[8*I_CORE +: 8];
  assign cal_v = reg_val[8*I_CAL +: 8];

  assign int_word_o = {outdiv_v[`SFC_INT_HIGH_HI:0], int_low_v};
  assign integer_mode_o = outdiv_v[`SFC_INT_MODE_BIT];
  assign output_polarity_invert_o = outdiv_v[`SFC_INVERT_BIT];
  assign calibration_enable_o = cal_v[`SFC_CAL_EN_BIT];
  assign spare_rw_bit_o = reg_val[8*I_SPARE + `SFC_SPARE_BIT];

  // first fraction: three bytes low first, then bit 0 of the core register
  assign first_fraction_word_o = {core_v[0], reg_val[8*I_F1B2 +: 8],
                                  reg_val[8*I_F1B1 +: 8], reg_val[8*I_F1B0 +: 8]};
  assign second_fraction_word_o = {reg_val[8*I_F2B2 +: 8], reg_val[8*I_F2B1 +: 8],
                                   reg_val[8*I_F2B0 +: 8]};
  assign second_modulus_low_o = reg_val[8*I_MOD2 +: 8];

  // divide ratio as a plain number so the output stage needs no decode
  always @* begin
    case (outdiv_v[`SFC_OUTDIV_HI:`SFC_OUTDIV_LO])
      2'h0: div_ratio = 4'h1;
      2'h1: div_ratio = 4'h2;
      2'h2: div_ratio = 4'h4;
      default: div_ratio = 4'h8;
    endcase
  end
  assign output_divide_ratio_o = div_ratio;

  // manual values only take effect under their override flag
  assign manual_core_select_o = core_v[`SFC_CORE_HI:`SFC_CORE_LO];
  assign manual_core_valid_o = core_override_flag_i;
  assign manual_bias_level_o = core_v[`SFC_BIAS_HI:`SFC_BIAS_LO];
  assign manual_bias_valid_o = bias_override_flag_i;
  assign manual_band_select_o = reg_val[8*I_BAND +: 8];
  assign manual_band_valid_o = band_override_flag_i;

  // ==========================================================
  // calibration start
  // ==========================================================
  // the start acts on the setting as it stands, so the low byte should land last
  sfc_cal_start u_cal_start (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .int_low_wr_i(wr_sel[I_INT_LOW]),
    .cal_enable_i(calibration_enable_o),
    .cal_start_o(cal_start_o)
  );

  // ==========================================================
  // read path
  // ==========================================================
  reg [7:0] rdata_d;
  reg [7:0] rdata_q;

  // unmapped offsets read zero
  always @* begin
    case (reg_addr_i)
      `SFC_OFF_MAKER_LOW: rdata_d = MAKER_CODE[7:0];
      `SFC_OFF_MAKER_HIGH: rdata_d = MAKER_CODE[15:8];
      `SFC_OFF_SPARE: rdata_d = reg_val[8*I_SPARE +: 8];
      `SFC_OFF_INT_LOW: rdata_d = int_low_v;
      `SFC_OFF_OUTDIV_MODE: rdata_d = outdiv_v;
      `SFC_OFF_FRAC1_B0: rdata_d = reg_val[8*I_F1B0 +: 8];
      `SFC_OFF_FRAC1_B1: rdata_d = reg_val[8*I_F1B1 +: 8];
      `SFC_OFF_FRAC1_B2: rdata_d = reg_val[8*I_F1B2 +: 8];
      `SFC_OFF_CORE_BIAS: rdata_d = core_v;
      `SFC_OFF_BAND: rdata_d = reg_val[8*I_BAND +: 8];
      `SFC_OFF_FRAC2_B0: rdata_d = reg_val[8*I_F2B0 +: 8];
      `SFC_OFF_FRAC2_B1: rdata_d = reg_val[8*I_F2B1 +: 8];
      `SFC_OFF_FRAC2_B2: rdata_d = reg_val[8*I_F2B2 +: 8];
      `SFC_OFF_MOD2_B0: rdata_d = reg_val[8*I_MOD2 +: 8];
      `SFC_OFF_CAL_CTRL: rdata_d = cal_v;
      default: rdata_d = `SFC_RST_ZERO;
    endcase
  end

  // read data is registered and holds until the next read
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      rdata_q <= `SFC_RST_ZERO;
    end else if (reg_rd_i) begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;

endmodule // sfc_config_regs

// ===== include/sfc_regs.vh
// register offsets, field positions, reset values and timing for the synthesizer config bank
`ifndef SFC_REGS_VH
`define SFC_REGS_VH

// register offsets
`define SFC_ADDR_W 7
`define SFC_OFF_MAKER_LOW 7'h0c
`define SFC_OFF_MAKER_HIGH 7'h0d
`define SFC_OFF_SPARE 7'h0f
`define SFC_OFF_INT_LOW 7'h10
`define SFC_OFF_OUTDIV_MODE 7'h11
`define SFC_OFF_FRAC1_B0 7'h12
`define SFC_OFF_FRAC1_B1 7'h13
`define SFC_OFF_FRAC1_B2 7'h14
`define SFC_OFF_CORE_BIAS 7'h15
`define SFC_OFF_BAND 7'h16
`define SFC_OFF_FRAC2_B0 7'h17
`define SFC_OFF_FRAC2_B1 7'h18
`define SFC_OFF_FRAC2_B2 7'h19
`define SFC_OFF_MOD2_B0 7'h1a
`define SFC_OFF_CAL_CTRL 7'h20

// reset values
`define SFC_RST_INT_LOW 8'h80
`define SFC_RST_ZERO 8'h00
`define SFC_RST_CAL_CTRL 8'h01

// field positions
`define SFC_OUTDIV_HI 7
`define SFC_OUTDIV_LO 6
`define SFC_INT_MODE_BIT 5
`define SFC_INVERT_BIT 4
`define SFC_INT_HIGH_HI 3
`define SFC_CORE_HI 7
`define SFC_CORE_LO 6
`define SFC_BIAS_HI 5
`define SFC_BIAS_LO 2
`define SFC_CAL_EN_BIT 7
`define SFC_SPARE_BIT 0

// timing: one clock cycle for the calibration start strobe
`define SFC_CAL_PULSE_CYC 1

`endif

// ===== tb/sfc_config_regs_assertions.sv
// concurrent checks on the ports of the synthesizer config register bank
module sfc_config_regs_chk #(
  parameter logic [15:0] MAKER_CODE = 16'h1234
) (
  // clock, reset and register access
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  // settings
  input wire logic [11:0] int_word_o,
  input wire logic [24:0] first_fraction_word_o,
  input wire logic [7:0] second_modulus_low_o,
  input wire logic [3:0] output_divide_ratio_o,
  input wire logic integer_mode_o,
  input wire logic output_polarity_invert_o,
  input wire logic calibration_enable_o,
  input wire logic cal_start_o,
  input wire logic core_override_flag_i,
  input wire logic manual_core_valid_o
);
  // ==========
  // decode of the accesses the checks key on
  wire w10 = reg_wr_i && reg_addr_i == 7'h10;
  wire w11 = reg_wr_i && reg_addr_i == 7'h11;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  property p_cal_on; w10 && calibration_enable_o |=> cal_start_o; endproperty
  a_cal_on: assert property (p_cal_on) else $error("no calibration start");
  property p_cal_off; !(w10 && calibration_enable_o) |=> !cal_start_o; endproperty
  a_cal_off: assert property (p_cal_off) else $error("spurious calibration start");
  property p_en; reg_wr_i && reg_addr_i == 7'h20 |=>
    calibration_enable_o == $past(reg_wdata_i[7]); endproperty
  a_en: assert property (p_en) else $error("enable bit not stored");
  property p_int; w10 |=> int_word_o[7:0] == $past(reg_wdata_i); endproperty
  a_int: assert property (p_int) else $error("integer low byte wrong");
  property p_div; w11 |=> output_divide_ratio_o == 4'h1 << $past(reg_wdata_i[7:6]); endproperty
  a_div: assert property (p_div) else $error("divide ratio wrong");
  property p_mode; w11 |=> integer_mode_o == $past(reg_wdata_i[5]); endproperty
  a_mode: assert property (p_mode) else $error("mode bit wrong");
  property p_inv; w11 |=> output_polarity_invert_o == $past(reg_wdata_i[4]); endproperty
  a_inv: assert property (p_inv) else $error("invert bit wrong");
  property p_frac; reg_wr_i && reg_addr_i == 7'h15 |=>
    first_fraction_word_o[24] == $past(reg_wdata_i[0]); endproperty
  a_frac: assert property (p_frac) else $error("fraction top bit wrong");
  property p_mod; reg_wr_i && reg_addr_i == 7'h1a |=> second_modulus_low_o == $past(reg_wdata_i);
  endproperty
  a_mod: assert property (p_mod) else $error("modulus byte wrong");
  property p_maker; reg_rd_i && reg_addr_i == 7'h0d |=> reg_rdata_o == MAKER_CODE[15:8];
  endproperty
  a_maker: assert property (p_maker) else $error("maker code high wrong");
  property p_spare; reg_rd_i && reg_addr_i == 7'h0f |=> reg_rdata_o[7:1] == 7'h00; endproperty
  a_spare: assert property (p_spare) else $error("spare register upper bits set");
  property p_core; manual_core_valid_o == core_override_flag_i; endproperty
  a_core: assert property (p_core) else $error("core valid not following flag");
endmodule // sfc_config_regs_chk

bind sfc_config_regs sfc_config_regs_chk #(.MAKER_CODE(MAKER_CODE)) i_chk (.*);

// ===== tb/sfc_host_model.sv
// host model issuing single byte register writes and reads
module sfc_host_model (
  // clock
  input wire logic clk_i,
  // register access
  output logic reg_wr_o = 1'b0,
  output logic reg_rd_o = 1'b0,
  output logic [6:0] reg_addr_o = 7'h00,
  output logic [7:0] reg_wdata_o = 8'h00,
  input wire logic [7:0] reg_rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // released lines show the inverse of the last value, never a stale copy
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    @(posedge clk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_rd_o <= 1'b1;
    reg_addr_o <= a;
    @(posedge clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    #1 d = reg_rdata_i;
  endtask
endmodule // sfc_host_model

// ===== tb/synth_freq_config_regs_tb.sv
// self-checking bench of the synthesizer config register bank
module synth_freq_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  localparam logic [15:0] MK = 16'hbeef; // arbitrary maker code
  logic clk_i = 1'b0, rstn_i = 1'b0, reg_wr_i, reg_rd_i;
  logic core_override_flag_i = 1'b0, bias_override_flag_i = 1'b0, band_override_flag_i = 1'b0;
  logic [6:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, second_modulus_low_o, manual_band_select_o, d;
  logic [11:0] int_word_o;
  logic [24:0] first_fraction_word_o;
  logic [23:0] second_fraction_word_o;
  logic [3:0] output_divide_ratio_o, manual_bias_level_o;
  logic [1:0] manual_core_select_o;
  logic integer_mode_o, output_polarity_invert_o, spare_rw_bit_o, calibration_enable_o;
  logic manual_core_valid_o, manual_bias_valid_o, manual_band_valid_o, cal_start_o;
  int fail_count = 0;
  int n_checks = 0;
  // rows of {offset, written byte, byte read back}
  logic [22:0] rows [16] = '{{7'h0c, 8'hff, MK[7:0]}, {7'h0d, 8'hff, MK[15:8]},
    {7'h0f, 8'hff, 8'h01}, {7'h10, 8'h3c, 8'h3c}, {7'h11, 8'ha7, 8'ha7}, {7'h12, 8'h11, 8'h11},
    {7'h13, 8'h22, 8'h22}, {7'h14, 8'h33, 8'h33}, {7'h15, 8'he9, 8'he9}, {7'h16, 8'hff, 8'hff},
    {7'h17, 8'h44, 8'h44}, {7'h18, 8'h55, 8'h55}, {7'h19, 8'h66, 8'h66}, {7'h1a, 8'h77, 8'h77},
    {7'h20, 8'hff, 8'h81}, {7'h30, 8'hff, 8'h00}};
  sfc_host_model i_host (.clk_i(clk_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
    .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o));
  sfc_config_regs #(.MAKER_CODE(MK)) i_dut (.*);
  initial forever #20 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // a hang is cut well beyond the roughly 115 cycles the tests need
  initial begin
    repeat (3000) @(posedge clk_i);
    fail_count++;
    end_sim();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    foreach (rows[i]) begin
      i_host.wr(rows[i][22:16], rows[i][15:8]);
      i_host.rd(rows[i][22:16], d);
      chk(d, rows[i][7:0]);
    end
    chk(int_word_o, 12'h73c);
    chk(first_fraction_word_o, 25'h1332211);
    chk(second_fraction_word_o, 24'h665544);
    chk({integer_mode_o, output_polarity_invert_o, output_divide_ratio_o}, 6'h24);
    chk({manual_core_select_o, manual_bias_level_o, manual_band_select_o},
        14'h3aff);
    chk({spare_rw_bit_o, second_modulus_low_o}, 9'h177);
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_i);
      {core_override_flag_i, bias_override_flag_i, band_override_flag_i} <= k[2:0];
      #1 chk({manual_core_valid_o, manual_bias_valid_o, manual_band_valid_o},
             k);
    end
    for (int i = 0; i < 4; i++) begin
      i_host.wr(7'h11, {i[1:0], 6'h10});
      #1 chk({output_divide_ratio_o, output_polarity_invert_o}, {4'h1 << i, 1'b1});
    end
    // second reset in mid-run restores the defaults
    @(posedge clk_i);
    rstn_i <= 1'b0;
    @(posedge clk_i);
    rstn_i <= 1'b1;
    #1 chk({int_word_o, output_divide_ratio_o, calibration_enable_o},
           {12'h080, 4'h1, 1'b0});
    chk({first_fraction_word_o, output_polarity_invert_o, integer_mode_o, spare_rw_bit_o},
        28'h0);
    i_host.rd(7'h20, d);
    chk(d, 8'h01);
    i_host.wr(7'h10, 8'h42);
    #1 chk(cal_start_o, 1'b0);
    i_host.wr(7'h20, 8'h80);
    i_host.wr(7'h12, 8'h5a); // fraction low byte first, integer low byte last
    i_host.wr(7'h10, 8'h43);
    #1 chk(cal_start_o, 1'b1);
    @(posedge clk_i);
    #1 chk(cal_start_o, 1'b0);
    end_sim();
  end
endmodule // synth_freq_config_regs_tb
